// [ncq_regs.sv]
// register bank: status, command, soft reset and command stream queue
`timescale 1ns/1ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module ncq_regs #(
  parameter int ADDR_W = 6
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [ADDR_W-1:0]     avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWriteData,
  input  wire logic [3:0]            avsByteEnable,
  output logic [31:0]                avsReadData,
  output logic                       avsWaitRequest,
  output logic [1:0]                 avsResponse,
  input  wire logic                  hostPermitted,
  input  wire logic                  hostPrivileged,
  input  wire ncq_pkg::ncq_engine_evt_t engineEvt,
  input  wire logic                  engineStop,
  output ncq_pkg::ncq_fetch_cfg_t    fetchCfg,
  output logic                       goStrobe,
  output logic                       softResetPulse,
  output logic                       ramClearPulse,
  output logic                       powerQAllow,
  output logic                       clockQAllow,
  output logic                       clockGateEnable,
  output logic                       irqOut
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < 6) begin : gAddrCheck
    $error("address width too small for the register map");
  end
  if (ncq_pkg::HIST_LSB + ncq_pkg::HIST_W > 32) begin : gHistCheck
    $error("history field does not fit the status word");
  end
  if (ncq_pkg::EVT_RESET >= ncq_pkg::EVT_W) begin : gEvtCheck
    $error("event status too narrow for its sources");
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle: the request is served on the edge where waitrequest is low
  // waitrequest idles high, so no request completes on the edge it first appears
  logic        ackQ;
  logic        accept;
  logic        wrHit;
  logic        rdHit;
  logic [31:0] beMask;
  logic [5:0]  addrW;

  assign accept = (avsRead | avsWrite) & ~ackQ;
  assign wrHit  = avsWrite & ackQ;
  assign rdHit  = avsRead & ackQ;
  assign addrW  = avsAddress[5:0];

  // byte lanes widen to a bit mask for the merging registers
  generate
    for (genvar b = 0; b < 4; b++) begin : gBe
      assign beMask[8*b +: 8] = {8{avsByteEnable[b]}};
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= accept;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avsWaitRequest <= 1'b1;
    end else begin
      avsWaitRequest <= ~accept;
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  logic        runQ;
  logic        irqQ;
  logic        endQ;
  logic [15:0] histQ;
  logic [31:0] cmdQ;
  logic [31:0] rstQ;
  logic [31:0] baseLowQ;
  logic [31:0] baseHighQ;
  logic [31:0] attrQ;
  logic [31:0] lenQ;
  logic [31:0] fetchOfsQ;
  logic [ncq_pkg::EVT_W-1:0] evtStatQ;
  logic [ncq_pkg::EVT_W-1:0] evtMaskQ;
  logic [31:0] cmdWr;
  logic        softRstWr;
  logic        anyRst;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign cmdWr = merge(cmdQ, avsWriteData, beMask);
  assign softRstWr = wrHit && addrW == ncq_pkg::OFS_SOFT_RESET && hostPermitted;
  // the bus handshake ignores a soft reset so the write that caused it still completes
  assign anyRst    = sys_rst | softResetPulse;

  // go starts running
  // a go in the same cycle as engineStop wins
  always_ff @(posedge clk) begin
    if (anyRst) begin
      runQ <= 1'b0;
    end else if (wrHit && addrW == ncq_pkg::OFS_COMMAND && cmdWr[ncq_pkg::CMD_GO]) begin
      runQ <= 1'b1;
    end else if (engineStop) begin
      runQ <= 1'b0;
    end
  end

  // clear on write of one; a new interrupt wins over the clear
  always_ff @(posedge clk) begin
    if (anyRst) begin
      irqQ <= 1'b0;
    end else if (engineEvt.irqPulse) begin
      irqQ <= 1'b1;
    end else if (wrHit && addrW == ncq_pkg::OFS_COMMAND && cmdWr[ncq_pkg::CMD_CLR_IRQ]) begin
      irqQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      histQ <= '0;
    end else begin
      histQ <= (histQ & ~((wrHit && addrW == ncq_pkg::OFS_COMMAND)
                          ? cmdWr[ncq_pkg::HIST_LSB +: ncq_pkg::HIST_W] : 16'h0000))
               | (engineEvt.irqPulse ? engineEvt.irqMask : 16'h0000);
    end
  end

  // end flag cleared by base or length write while stopped
  // a set in the same cycle as a clearing write wins, so no end is lost
  always_ff @(posedge clk) begin
    if (anyRst) begin
      endQ <= 1'b0;
    end else if (engineEvt.endReached) begin
      endQ <= 1'b1;
    end else if (wrHit && !runQ && (addrW == ncq_pkg::OFS_BASE_LOW ||
                 addrW == ncq_pkg::OFS_BASE_HIGH || addrW == ncq_pkg::OFS_LENGTH)) begin
      endQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      cmdQ <= ncq_pkg::CMD_RESET;
    end else if (wrHit && addrW == ncq_pkg::OFS_COMMAND) begin
      cmdQ <= cmdWr & ncq_pkg::CMD_KEEP_MASK;
    end
  end

  // privilege request capped at host level
  // privilege level
  // only a hard reset clears it, so a soft reset keeps the new request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstQ <= ncq_pkg::ZERO_WORD;
    end else if (softRstWr) begin
      rstQ <= {30'h00000000, avsWriteData[ncq_pkg::RST_SEC],
               avsWriteData[ncq_pkg::RST_PRIV] & hostPrivileged} & ncq_pkg::RST_KEEP_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      baseLowQ  <= ncq_pkg::ZERO_WORD;
      baseHighQ <= ncq_pkg::ZERO_WORD;
      attrQ     <= ncq_pkg::ZERO_WORD;
      lenQ      <= ncq_pkg::ZERO_WORD;
    end else if (wrHit) begin
      case (addrW)
        ncq_pkg::OFS_BASE_LOW:  baseLowQ  <= merge(baseLowQ, avsWriteData, beMask);
        ncq_pkg::OFS_BASE_HIGH: baseHighQ <= merge(baseHighQ, avsWriteData, beMask);
        ncq_pkg::OFS_BUS_ATTR:  attrQ     <= merge(attrQ, avsWriteData, beMask);
        ncq_pkg::OFS_LENGTH:    lenQ      <= merge(lenQ, avsWriteData, beMask);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      fetchOfsQ <= ncq_pkg::ZERO_WORD;
    end else if (engineEvt.offsetValid) begin
      fetchOfsQ <= {8'h00, engineEvt.offset[ncq_pkg::OFS_W-1:2], 2'b00};
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [ncq_pkg::EVT_W-1:0] evtIn;
  logic                      statRd;
  always_comb begin
    evtIn                     = '0;
    evtIn[ncq_pkg::EVT_IRQ]   = engineEvt.irqPulse;
    evtIn[ncq_pkg::EVT_END]   = engineEvt.endReached;
    evtIn[ncq_pkg::EVT_RESET] = softResetPulse;
  end
  assign statRd = rdHit && addrW == ncq_pkg::OFS_IRQ_STATUS;

  // read clears, but an event in the same cycle survives
  // a soft reset leaves these bits alone, so its own done event is kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evtStatQ <= '0;
    end else begin
      evtStatQ <= (statRd ? '0 : evtStatQ) | evtIn;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evtMaskQ <= '0;
    end else if (wrHit && addrW == ncq_pkg::OFS_IRQ_MASK) begin
      evtMaskQ <= avsWriteData[ncq_pkg::EVT_W-1:0];
    end
  end

  // built from the next status, so the pin follows a set or a read-clear at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(((statRd ? '0 : evtStatQ) | evtIn) & evtMaskQ);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // an unmapped address answers with a decode error and reads as zero
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // status word built from the field positions; unlisted fields read zero
  logic [31:0] statusWord;
  always_comb begin
    statusWord                                       = ncq_pkg::ZERO_WORD;
    statusWord[ncq_pkg::STAT_RUN]                    = runQ;
    statusWord[ncq_pkg::STAT_IRQ]                    = irqQ;
    statusWord[ncq_pkg::STAT_END]                    = endQ;
    statusWord[ncq_pkg::HIST_LSB +: ncq_pkg::HIST_W] = histQ;
  end

  logic [31:0] rdMux;
  logic        rdMiss;
  always_comb begin
    rdMux  = ncq_pkg::ZERO_WORD;
    rdMiss = 1'b0;
    case (addrW)
      ncq_pkg::OFS_STATUS:     rdMux = statusWord;
      ncq_pkg::OFS_COMMAND:    rdMux = cmdQ;
      ncq_pkg::OFS_SOFT_RESET: rdMux = rstQ;
      ncq_pkg::OFS_BASE_LOW:   rdMux = baseLowQ;
      ncq_pkg::OFS_BASE_HIGH:  rdMux = baseHighQ;
      ncq_pkg::OFS_FETCH_OFS:  rdMux = fetchOfsQ;
      ncq_pkg::OFS_BUS_ATTR:   rdMux = attrQ;
      ncq_pkg::OFS_LENGTH:     rdMux = lenQ;
      ncq_pkg::OFS_IRQ_STATUS: rdMux = {29'h00000000, evtStatQ};
      ncq_pkg::OFS_IRQ_MASK:   rdMux = {29'h00000000, evtMaskQ};
      default:                 rdMiss = 1'b1;
    endcase
  end

  // data is registered in the accept cycle and stands on the wait-low edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avsReadData <= ncq_pkg::ZERO_WORD;
      avsResponse <= RESP_OKAY;
    end else if (accept) begin
      avsReadData <= (avsRead && !rdMiss) ? rdMux : ncq_pkg::ZERO_WORD;
      avsResponse <= rdMiss ? RESP_DECERR : RESP_OKAY;
    end
  end

  // ---------------------------------------------------------------
  // outputs toward the engine
  // ---------------------------------------------------------------
  // reset and RAM clear pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      softResetPulse <= 1'b0;
      ramClearPulse  <= 1'b0;
    end else begin
      softResetPulse <= softRstWr;
      ramClearPulse  <= softRstWr;
    end
  end

  // one-cycle start pulse toward the engine, raised only by a go write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      goStrobe <= 1'b0;
    end else begin
      goStrobe <= wrHit && addrW == ncq_pkg::OFS_COMMAND && cmdWr[ncq_pkg::CMD_GO];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powerQAllow     <= 1'b1;
      clockQAllow     <= 1'b1;
      clockGateEnable <= 1'b1;
    end else begin
      powerQAllow     <= cmdQ[ncq_pkg::CMD_PWR_Q];
      clockQAllow     <= cmdQ[ncq_pkg::CMD_CLK_Q];
      clockGateEnable <= cmdQ[ncq_pkg::CMD_CLK_Q];
    end
  end

  // 40-bit fetch address; low bits forced aligned
  // the engine sees a new base one cycle after the write lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetchCfg <= '0;
    end else begin
      fetchCfg.baseAddr       <= {baseHighQ[ncq_pkg::BASE_HIGH_W-1:0], baseLowQ[31:2], 2'b00};
      fetchCfg.busAttr        <= attrQ[ncq_pkg::ATTR_W-1:0];
      fetchCfg.securityLevel  <= rstQ[ncq_pkg::RST_SEC];
      fetchCfg.privilegeLevel <= rstQ[ncq_pkg::RST_PRIV];
    end
  end

endmodule

// [ncq_pkg.sv]
// package for the neural processing unit control and queue register bank
package ncq_pkg;

  // ---------------------------------------------------------------
  // register byte addresses (word aligned)
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_STATUS      = 6'h00;
  localparam logic [5:0] OFS_COMMAND     = 6'h04;
  localparam logic [5:0] OFS_SOFT_RESET  = 6'h08;
  localparam logic [5:0] OFS_BASE_LOW    = 6'h0C;
  localparam logic [5:0] OFS_BASE_HIGH   = 6'h10;
  localparam logic [5:0] OFS_FETCH_OFS   = 6'h14;
  localparam logic [5:0] OFS_BUS_ATTR    = 6'h18;
  localparam logic [5:0] OFS_LENGTH      = 6'h1C;
  localparam logic [5:0] OFS_IRQ_STATUS  = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK    = 6'h24;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STAT_RUN       = 0;
  localparam int STAT_IRQ       = 1;
  localparam int STAT_END       = 5;
  localparam int HIST_LSB       = 16;
  localparam int HIST_W         = 16;
  localparam int CMD_GO         = 0;
  localparam int CMD_CLR_IRQ    = 1;
  localparam int CMD_CLK_Q      = 2;
  localparam int CMD_PWR_Q      = 3;
  localparam int RST_PRIV       = 0;
  localparam int RST_SEC        = 1;
  localparam int BASE_HIGH_W    = 8;
  localparam int ATTR_W         = 2;
  localparam int OFS_W          = 24;
  localparam int EVT_W          = 3;
  localparam int EVT_IRQ        = 0;
  localparam int EVT_END        = 1;
  localparam int EVT_RESET      = 2;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [31:0] CMD_RESET      = 32'h0000000C;
  localparam logic [31:0] CMD_KEEP_MASK  = 32'hFFFF000F;
  localparam logic [31:0] RST_KEEP_MASK  = 32'h00000003;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;
  localparam logic [31:0] BAD_ADDR_READ  = 32'hDEADBEEF;

  typedef struct packed {
    logic [39:0]        baseAddr;
    logic [ATTR_W-1:0]  busAttr;
    logic               securityLevel;
    logic               privilegeLevel;
  } ncq_fetch_cfg_t;

  typedef struct packed {
    logic               irqPulse;
    logic [HIST_W-1:0]  irqMask;
    logic               endReached;
    logic               offsetValid;
    logic [OFS_W-1:0]   offset;
  } ncq_engine_evt_t;

endpackage

// [ncq_host.sv]
// host bus master model for the register bank
`timescale 1ns/1ps
module ncq_host (
  input  wire logic        clk,
  input  wire logic        avsWaitRequest,
  input  wire logic [31:0] avsReadData,
  output logic [5:0]       avsAddress,
  output logic             avsRead,
  output logic             avsWrite,
  output logic [31:0]      avsWriteData,
  output logic [3:0]       avsByteEnable
);
  // full-word accesses only; byte lanes are left to later work
  assign avsByteEnable = 4'hF;
  initial begin
    avsAddress = 6'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h00000000;
  end
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge clk);
    while (avsWaitRequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    // released data shows the inverse so a stale value is never trusted
    avsWriteData <= ~d;
  endtask
endmodule

// [ncq_regs_assertions.sv]
// port checker for the register bank
`timescale 1ns/1ps
module ncq_chk (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic [5:0]              avsAddress,
  input wire logic                    avsRead,
  input wire logic                    avsWrite,
  input wire logic [31:0]             avsWriteData,
  input wire logic [3:0]              avsByteEnable,
  input wire logic                    avsWaitRequest,
  input wire logic                    hostPermitted,
  input wire ncq_pkg::ncq_fetch_cfg_t fetchCfg,
  input wire logic                    goStrobe,
  input wire logic                    softResetPulse,
  input wire logic                    ramClearPulse,
  input wire logic                    powerQAllow,
  input wire logic                    clockQAllow,
  input wire logic                    clockGateEnable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic cmdDone;
  logic srDone;
  assign cmdDone = avsWrite && !avsWaitRequest && avsAddress == ncq_pkg::OFS_COMMAND;
  assign srDone = avsWrite && !avsWaitRequest && avsAddress == ncq_pkg::OFS_SOFT_RESET;
  wait_one_a : assert property ((avsRead || avsWrite) && avsWaitRequest
    |=> !avsWaitRequest ##1 avsWaitRequest) else $error("wait not one cycle");
  go_pulse_a : assert property (cmdDone && avsWriteData[0] && avsByteEnable[0]
    |-> ##[0:2] goStrobe) else $error("go strobe missing");
  go_cause_a : assert property (goStrobe |-> $past(cmdDone) || $past(cmdDone, 2))
    else $error("go strobe without write");
  rst_pulse_a : assert property (srDone && hostPermitted |-> ##[0:2] softResetPulse)
    else $error("soft reset missing");
  rst_deny_a : assert property (srDone && !hostPermitted
    |-> ##1 !softResetPulse [*2]) else $error("refused soft reset ran");
  ram_clear_a : assert property (softResetPulse |-> ramClearPulse)
    else $error("ram clear missing");
  perm_init_a : assert property ($fell(sys_rst) |-> powerQAllow && clockQAllow)
    else $error("permissions not set after reset");
  gate_tie_a : assert property (clockGateEnable == clockQAllow)
    else $error("clock gate differs from permission");
  base_hold_a : assert property ($changed(fetchCfg.baseAddr)
    |-> $past(avsWrite) || $past(avsWrite, 2) || $past(softResetPulse)
    || $past(softResetPulse, 2)) else $error("base moved without cause");
endmodule
bind ncq_regs ncq_chk chk_u (.clk, .sys_rst, .avsAddress, .avsRead, .avsWrite,
  .avsWriteData, .avsByteEnable, .avsWaitRequest, .hostPermitted, .fetchCfg, .goStrobe,
  .softResetPulse, .ramClearPulse, .powerQAllow, .clockQAllow, .clockGateEnable);

// [testbench.sv]
// self-checking bench for the register bank
`timescale 1ns/1ps
module testbench;
  logic                     clk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic [5:0]               avsAddress;
  logic                     avsRead;
  logic                     avsWrite;
  logic [31:0]              avsWriteData;
  logic [3:0]               avsByteEnable;
  logic [31:0]              avsReadData;
  logic                     avsWaitRequest;
  logic                     hostPermitted = 1'b0;
  logic                     hostPrivileged = 1'b0;
  ncq_pkg::ncq_engine_evt_t engineEvt = '0;
  logic                     engineStop = 1'b0;
  ncq_pkg::ncq_fetch_cfg_t  fetchCfg;
  logic                     goStrobe;
  logic                     softResetPulse;
  logic                     powerQAllow;
  logic                     clockQAllow;
  logic                     irqOut;
  logic [1:0]               avsResponse;
  logic                     ramClearPulse;
  logic                     clockGateEnable;
  logic [31:0]              rdv;
  int                       err_total = 0;
  int                       cmp_count = 0;
  int                       rstSeen = 0;
  int                       clrSeen = 0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (softResetPulse === 1'b1) rstSeen++;
    if (ramClearPulse === 1'b1) clrSeen++;
  end
  ncq_host host_u (.clk, .avsWaitRequest, .avsReadData, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsByteEnable);
  ncq_regs dut_u (.clk, .sys_rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .avsResponse, .hostPermitted,
    .hostPrivileged, .engineEvt, .engineStop, .fetchCfg, .goStrobe, .softResetPulse,
    .ramClearPulse, .powerQAllow, .clockQAllow, .clockGateEnable, .irqOut);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h00000000, rdv);
    chk(rdv & m, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rdv);
  endtask
  task automatic evt(input ncq_pkg::ncq_engine_evt_t e);
    @(posedge clk);
    engineEvt <= e;
    @(posedge clk);
    engineEvt <= '0;
  endtask
  task automatic t_reset;
    rdc(ncq_pkg::OFS_STATUS, 32'hFFFF0023, 32'h0);
    rdc(ncq_pkg::OFS_COMMAND, '1, ncq_pkg::CMD_RESET);
    rdc(ncq_pkg::OFS_SOFT_RESET, '1, 32'h0);
    for (int i = 3; i < 8; i++) begin
      rdc(6'(4 * i), '1, 32'h0);
    end
    chk({29'h0, clockGateEnable, powerQAllow, clockQAllow}, 32'h7);
  endtask
  task automatic t_cmd;
    wr(ncq_pkg::OFS_COMMAND, 32'hFFFFFFF2);
    rdc(ncq_pkg::OFS_COMMAND, '1, 32'hFFFF0002);
    chk({29'h0, clockGateEnable, powerQAllow, clockQAllow}, 32'h0);
    wr(ncq_pkg::OFS_COMMAND, 32'h0000000C);
    rdc(ncq_pkg::OFS_STATUS, 32'h1, 32'h0);
    chk({29'h0, clockGateEnable, powerQAllow, clockQAllow}, 32'h7);
    wr(ncq_pkg::OFS_COMMAND, 32'h0000000D);
    rdc(ncq_pkg::OFS_STATUS, 32'h1, 32'h1);
    wr(ncq_pkg::OFS_COMMAND, 32'h0000000C);
    rdc(ncq_pkg::OFS_STATUS, 32'h1, 32'h1);
    @(posedge clk);
    engineStop <= 1'b1;
    @(posedge clk);
    engineStop <= 1'b0;
    rdc(ncq_pkg::OFS_STATUS, 32'h1, 32'h0);
  endtask
  task automatic t_irq;
    evt({1'b1, 16'hA5A5, 26'h0});
    rdc(ncq_pkg::OFS_STATUS, 32'hFFFF0002, 32'hA5A50002);
    wr(ncq_pkg::OFS_COMMAND, 32'h0000000C);
    rdc(ncq_pkg::OFS_STATUS, 32'hFFFF0002, 32'hA5A50002);
    wr(ncq_pkg::OFS_COMMAND, 32'h0005000E);
    rdc(ncq_pkg::OFS_STATUS, 32'hFFFF0002, 32'hA5A00000);
    rdc(ncq_pkg::OFS_IRQ_STATUS, '1, 32'h1);
    wr(ncq_pkg::OFS_IRQ_MASK, 32'h0);
    evt({1'b1, 16'h0001, 26'h0});
    repeat (3) @(posedge clk);
    chk({31'h0, irqOut}, 32'h0);
    rdc(ncq_pkg::OFS_IRQ_STATUS, '1, 32'h1);
    wr(ncq_pkg::OFS_IRQ_MASK, 32'h1);
    evt({1'b1, 16'h0001, 26'h0});
    repeat (3) @(posedge clk);
    chk({31'h0, irqOut}, 32'h1);
    rdc(ncq_pkg::OFS_IRQ_STATUS, '1, 32'h1);
    rdc(ncq_pkg::OFS_IRQ_STATUS, '1, 32'h0);
    chk({31'h0, irqOut}, 32'h0);
  endtask
  task automatic t_soft;
    wr(ncq_pkg::OFS_SOFT_RESET, 32'h3);
    rdc(ncq_pkg::OFS_SOFT_RESET, '1, 32'h0);
    chk(32'(rstSeen), 32'h0);
    wr(ncq_pkg::OFS_COMMAND, 32'h0);
    hostPermitted <= 1'b1;
    wr(ncq_pkg::OFS_SOFT_RESET, 32'hFFFFFFFF);
    rdc(ncq_pkg::OFS_SOFT_RESET, '1, 32'h2);
    chk(32'(rstSeen), 32'h1);
    chk(32'(clrSeen), 32'h1);
    rdc(ncq_pkg::OFS_IRQ_STATUS, 32'h4, 32'h4);
    rdc(ncq_pkg::OFS_COMMAND, '1, ncq_pkg::CMD_RESET);
    hostPrivileged <= 1'b1;
    // host asks only a level within its own privilege
    wr(ncq_pkg::OFS_SOFT_RESET, 32'h1);
    rdc(ncq_pkg::OFS_SOFT_RESET, '1, 32'h1);
  endtask
  task automatic t_queue;
    wr(ncq_pkg::OFS_BASE_LOW, 32'h12345678);
    wr(ncq_pkg::OFS_BASE_HIGH, 32'h000000AB);
    wr(ncq_pkg::OFS_BUS_ATTR, 32'h3);
    rdc(ncq_pkg::OFS_BASE_LOW, '1, 32'h12345678);
    chk({30'h0, avsResponse}, 32'h0);
    chk(fetchCfg.baseAddr[39:8], 32'hAB123456);
    chk({30'h0, fetchCfg.busAttr}, 32'h3);
    wr(ncq_pkg::OFS_FETCH_OFS, 32'hFFFFFFFF);
    rdc(ncq_pkg::OFS_FETCH_OFS, '1, 32'h0);
    evt({19'h1, 24'hFFFFFC});
    rdc(ncq_pkg::OFS_FETCH_OFS, '1, 32'h00FFFFFC);
    evt({17'h0, 1'b1, 25'h0});
    rdc(ncq_pkg::OFS_STATUS, 32'h20, 32'h20);
    // a base write while running must leave the end flag set
    wr(ncq_pkg::OFS_COMMAND, 32'h0000000D);
    wr(ncq_pkg::OFS_BASE_LOW, 32'h12345678);
    rdc(ncq_pkg::OFS_STATUS, 32'h21, 32'h21);
    @(posedge clk);
    engineStop <= 1'b1;
    @(posedge clk);
    engineStop <= 1'b0;
    wr(ncq_pkg::OFS_BASE_HIGH, 32'h000000AB);
    rdc(ncq_pkg::OFS_STATUS, 32'h20, 32'h0);
    rdc(6'h28, '1, 32'h0);
    chk({30'h0, avsResponse}, 32'h3);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_cmd;
    t_irq;
    t_soft;
    t_queue;
    close_out;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    close_out;
  end
endmodule
